// ==== hdl/caf_consts.vh ====
`ifndef CAF_CONSTS_VH
`define CAF_CONSTS_VH
// Register byte addresses
`define CAF_ADDR_BUFPTR0 8'h00
`define CAF_ADDR_BUFPTR1 8'h04
`define CAF_ADDR_BUFPTR2 8'h08
`define CAF_ADDR_BUFPTR3 8'h0C
`define CAF_ADDR_MSKSEL0 8'h10
`define CAF_ADDR_MSKSEL1 8'h14
`define CAF_ADDR_FLTACT 8'h18
`define CAF_ADDR_STATUS 8'h1C
`define CAF_ADDR_MASK_BASE 8'h20
`define CAF_ADDR_SID_BASE 8'h40
`define CAF_ADDR_EID_BASE 8'h80
`define CAF_ADDR_MASK_END 8'h38
`define CAF_ADDR_EID_END 8'hC0
`define CAF_ADDR_COUNT 8'hC0
// Field positions in the standard identifier word
`define CAF_SID_HI 15
`define CAF_SID_LO 5
`define CAF_XSEL_BIT 3
`define CAF_EIDH_HI 1
`define CAF_EIDH_LO 0
`define CAF_SID_WMASK 16'hFFEB
// Pointer and mask-select codes
`define CAF_PTR_FIFO 4'hF
`define CAF_MSRC_NONE 2'h3
// Reset values
`define CAF_RST_PTR 16'h0000
`define CAF_RST_MSKSEL 16'h0000
`define CAF_RST_FLTACT 16'hFFFF
`define CAF_RST_WORD 16'h0000
// Bus answers
`define CAF_RESP_OKAY 2'h0
`define CAF_RESP_SLVERR 2'h2
`endif

// ==== hdl/caf_filter_match.v ====
`timescale 1ns/1ns
// One acceptance filter compared against one message
module caf_filter_match (
   input wire [15:0] sid_word,
   input wire [15:0] eid_word,
   input wire filter_active,
   input wire [1:0] filter_mask_source,
   input wire [47:0] mask_words,
   input wire [10:0] msg_sid,
   input wire [17:0] msg_eid,
   input wire msg_ext,
   output wire hit
);
`include "caf_consts.vh"
   reg [15:0] msk_sid;
   reg [15:0] msk_eid;
   wire [28:0] flt_id;
   wire [28:0] msg_id;
   wire [28:0] cmp_mask;
   wire frame_type_match_enable;
   wire id_ok;
   wire type_ok;
   always @* begin
      case (filter_mask_source)
         2'h0: begin
            msk_sid = mask_words[15:0];
            msk_eid = mask_words[31:16];
         end
         2'h1: begin
            msk_sid = mask_words[47:32];
            msk_eid = mask_words[47:32];
         end
         default: begin
            msk_sid = 16'h0000;
            msk_eid = 16'h0000;
         end
      endcase
   end
   assign flt_id = {sid_word[`CAF_SID_HI:`CAF_SID_LO], sid_word[`CAF_EIDH_HI:`CAF_EIDH_LO], eid_word};
   assign msg_id = {msg_sid, msg_eid};
   // No mask compares every bit and the frame type
   assign cmp_mask = (filter_mask_source == `CAF_MSRC_NONE) ? {29{1'b1}} :
      {msk_sid[`CAF_SID_HI:`CAF_SID_LO], msk_sid[`CAF_EIDH_HI:`CAF_EIDH_LO], msk_eid};
   assign frame_type_match_enable = (filter_mask_source == `CAF_MSRC_NONE) ? 1'b1 : msk_sid[`CAF_XSEL_BIT];
   assign id_ok = ((flt_id ^ msg_id) & cmp_mask) == 29'h0;
   assign type_ok = !frame_type_match_enable || (sid_word[`CAF_XSEL_BIT] == msg_ext);
   assign hit = filter_active && id_ok && type_ok;
endmodule // caf_filter_match

// ==== hdl/caf_axil_slave.v ====
`timescale 1ns/1ns
// AXI4-Lite handshake; register storage lives in the parent
module caf_axil_slave (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axil_awaddr,
   input wire s_axil_awvalid,
   output reg s_axil_awready,
   input wire [31:0] s_axil_wdata,
   input wire [3:0] s_axil_wstrb,
   input wire s_axil_wvalid,
   output reg s_axil_wready,
   output reg [1:0] s_axil_bresp,
   output reg s_axil_bvalid,
   input wire s_axil_bready,
   input wire [7:0] s_axil_araddr,
   input wire s_axil_arvalid,
   output reg s_axil_arready,
   output reg [31:0] s_axil_rdata,
   output reg [1:0] s_axil_rresp,
   output reg s_axil_rvalid,
   input wire s_axil_rready,
   output wire wr_en,
   output wire [7:0] wr_addr,
   output wire [15:0] wr_data,
   output wire [1:0] wr_strb,
   input wire wr_ok,
   output wire [7:0] rd_addr,
   input wire [15:0] rd_data,
   input wire rd_ok
);
`include "caf_consts.vh"
   reg aw_have_q;
   reg w_have_q;
   reg [7:0] aw_q;
   reg [15:0] wd_q;
   reg [1:0] ws_q;
   // Write commits once both halves are held and no response is pending
   assign wr_en = aw_have_q && w_have_q && !s_axil_bvalid;
   assign wr_addr = aw_q;
   assign wr_data = wd_q;
   assign wr_strb = ws_q;
   assign rd_addr = s_axil_araddr;
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_q <= 8'h00;
         wd_q <= 16'h0000;
         ws_q <= 2'h0;
         s_axil_awready <= 1'b0;
         s_axil_wready <= 1'b0;
         s_axil_bvalid <= 1'b0;
         s_axil_bresp <= `CAF_RESP_OKAY;
         s_axil_arready <= 1'b0;
         s_axil_rvalid <= 1'b0;
         s_axil_rdata <= 32'h00000000;
         s_axil_rresp <= `CAF_RESP_OKAY;
      end else begin
         s_axil_awready <= !aw_have_q && s_axil_awvalid && !s_axil_awready;
         s_axil_wready <= !w_have_q && s_axil_wvalid && !s_axil_wready;
         if (s_axil_awvalid && s_axil_awready) begin
            aw_have_q <= 1'b1;
            aw_q <= {s_axil_awaddr[7:2], 2'h0};
         end
         if (s_axil_wvalid && s_axil_wready) begin
            w_have_q <= 1'b1;
            wd_q <= s_axil_wdata[15:0];
            ws_q <= s_axil_wstrb[1:0];
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= wr_ok ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
         end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
         end
         s_axil_arready <= s_axil_arvalid && !s_axil_arready && !s_axil_rvalid;
         if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata <= {16'h0000, rd_ok ? rd_data : 16'h0000};
            s_axil_rresp <= rd_ok ? `CAF_RESP_OKAY : `CAF_RESP_SLVERR;
         end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
         end
      end
   end
endmodule // caf_axil_slave

// ==== hdl/caf_rx_acceptance_filter.v ====
// Notes on behaviour
// - Pointer 1111 steers hit into FIFO
// - Pointer 0-14 steers hit to that buffer
// - Four pointer registers, four nibbles, ascending
// - Standard identifier in bits 15-5 matched
// - Extended identifier bits 1-0 plus 15-0
// - Extended select bit 3 picks frame type
// - Mask source 00/01/10 masks, 11 none
// - Filters 0-7 mask select, two bits each
// - Mask bit 1 compares, 0 ignores
// - Mask frame-type bit enforces extended select
// - Disabled filter accepts nothing
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/1ns
module caf_rx_acceptance_filter #(
   parameter NUM_FILTERS = 16
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axil_awaddr,
   input wire s_axil_awvalid,
   output wire s_axil_awready,
   input wire [31:0] s_axil_wdata,
   input wire [3:0] s_axil_wstrb,
   input wire s_axil_wvalid,
   output wire s_axil_wready,
   output wire [1:0] s_axil_bresp,
   output wire s_axil_bvalid,
   input wire s_axil_bready,
   input wire [7:0] s_axil_araddr,
   input wire s_axil_arvalid,
   output wire s_axil_arready,
   output wire [31:0] s_axil_rdata,
   output wire [1:0] s_axil_rresp,
   output wire s_axil_rvalid,
   input wire s_axil_rready,
   input wire msg_valid,
   input wire [10:0] msg_sid,
   input wire [17:0] msg_eid,
   input wire msg_ext,
   output reg accept_valid,
   output reg accept_to_fifo,
   output reg [3:0] accept_buffer,
   output reg [3:0] accept_filter
);
`include "caf_consts.vh"
   reg [15:0] ptr_q [0:3];
   reg [15:0] msksel_q [0:1];
   reg [15:0] fltact_q;
   reg [15:0] mask_q [0:5];
   reg [15:0] sid_q [0:15];
   reg [15:0] eid_q [0:15];
   reg [15:0] hits_q;
   reg [15:0] accept_count_q;
   wire wr_en;
   wire [7:0] wr_addr;
   wire [15:0] wr_data;
   wire [1:0] wr_strb;
   wire [7:0] rd_addr;
   reg [15:0] rd_data;
   reg rd_ok;
   reg wr_ok;
   wire [15:0] wmask;
   wire [15:0] hit_vec;
   wire [47:0] mask_words_all [0:2];
   reg [3:0] win_idx;
   reg win_any;
   reg [3:0] win_ptr;
   wire [7:0] rd_word;
   integer i;
   integer k;

   assign wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign rd_word = {rd_addr[7:2], 2'h0};
   // Mask set chosen here; the matcher only sees set 0 or no mask
   genvar m;
   generate
      for (m = 0; m < 3; m = m + 1) begin : g_msk
         assign mask_words_all[m] = {16'h0000, mask_q[2 * m + 1], mask_q[2 * m]};
      end
   endgenerate
   genvar g;
   generate
      for (g = 0; g < NUM_FILTERS; g = g + 1) begin : g_flt
         wire [1:0] msrc;
         reg [47:0] mw;
         assign msrc = msksel_q[g / 8][(g % 8) * 2 +: 2];
         always @* begin
            case (msrc)
               2'h0: mw = mask_words_all[0];
               2'h1: mw = mask_words_all[1];
               2'h2: mw = mask_words_all[2];
               default: mw = 48'h0;
            endcase
         end
         caf_filter_match u_match (
            .sid_word(sid_q[g]),
            .eid_word(eid_q[g]),
            .filter_active(fltact_q[g]),
            .filter_mask_source(msrc == `CAF_MSRC_NONE ? `CAF_MSRC_NONE : 2'h0),
            .mask_words(mw),
            .msg_sid(msg_sid),
            .msg_eid(msg_eid),
            .msg_ext(msg_ext),
            .hit(hit_vec[g])
         );
      end
   endgenerate

   // Lowest-numbered hitting filter wins
   always @* begin
      win_idx = 4'h0;
      win_any = 1'b0;
      for (i = NUM_FILTERS - 1; i >= 0; i = i - 1) begin
         if (hit_vec[i]) begin
            win_idx = i[3:0];
            win_any = 1'b1;
         end
      end
      win_ptr = ptr_q[win_idx[3:2]][win_idx[1:0] * 4 +: 4];
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         accept_valid <= 1'b0;
         accept_to_fifo <= 1'b0;
         accept_buffer <= 4'h0;
         accept_filter <= 4'h0;
         hits_q <= 16'h0000;
         accept_count_q <= 16'h0000;
      end else begin
         accept_valid <= msg_valid && win_any;
         if (msg_valid && win_any) begin
            accept_filter <= win_idx;
            accept_to_fifo <= (win_ptr == `CAF_PTR_FIFO);
            accept_buffer <= win_ptr;
            accept_count_q <= accept_count_q + 16'h0001;
         end
         if (msg_valid) begin
            hits_q <= hit_vec;
         end
      end
   end

   // Register writes
   always @(posedge aclk) begin
      if (!aresetn) begin
         for (k = 0; k < 4; k = k + 1) begin
            ptr_q[k] <= `CAF_RST_PTR;
         end
         msksel_q[0] <= `CAF_RST_MSKSEL;
         msksel_q[1] <= `CAF_RST_MSKSEL;
         fltact_q <= `CAF_RST_FLTACT;
         for (k = 0; k < 6; k = k + 1) begin
            mask_q[k] <= `CAF_RST_WORD;
         end
         for (k = 0; k < 16; k = k + 1) begin
            sid_q[k] <= `CAF_RST_WORD;
            eid_q[k] <= `CAF_RST_WORD;
         end
      end else if (wr_en && wr_ok) begin
         if (wr_addr < `CAF_ADDR_MSKSEL0) begin
            ptr_q[wr_addr[3:2]] <= (ptr_q[wr_addr[3:2]] & ~wmask) | (wr_data & wmask);
         end else if (wr_addr == `CAF_ADDR_MSKSEL0 || wr_addr == `CAF_ADDR_MSKSEL1) begin
            msksel_q[wr_addr[2]] <= (msksel_q[wr_addr[2]] & ~wmask) | (wr_data & wmask);
         end else if (wr_addr == `CAF_ADDR_FLTACT) begin
            fltact_q <= (fltact_q & ~wmask) | (wr_data & wmask);
         end else if (wr_addr >= `CAF_ADDR_SID_BASE && wr_addr < `CAF_ADDR_EID_BASE) begin
            sid_q[wr_addr[5:2]] <= (sid_q[wr_addr[5:2]] & ~(wmask & `CAF_SID_WMASK)) |
               (wr_data & wmask & `CAF_SID_WMASK);
         end else if (wr_addr >= `CAF_ADDR_EID_BASE && wr_addr < `CAF_ADDR_EID_END) begin
            eid_q[wr_addr[5:2]] <= (eid_q[wr_addr[5:2]] & ~wmask) | (wr_data & wmask);
         end else if (wr_addr >= `CAF_ADDR_MASK_BASE && wr_addr < `CAF_ADDR_MASK_END) begin
            mask_q[wr_addr[4:2]] <= (mask_q[wr_addr[4:2]] & ~wmask) | (wr_data & wmask);
         end
      end
   end

   // Address decode for both directions
   always @* begin
      // Status and count words are read-only, so writes there are refused
      wr_ok = (wr_addr < `CAF_ADDR_STATUS) ||
         (wr_addr >= `CAF_ADDR_MASK_BASE && wr_addr < `CAF_ADDR_MASK_END) ||
         (wr_addr >= `CAF_ADDR_SID_BASE && wr_addr < `CAF_ADDR_EID_END);
      rd_ok = 1'b1;
      rd_data = 16'h0000;
      if (rd_word < `CAF_ADDR_MSKSEL0) begin
         rd_data = ptr_q[rd_word[3:2]];
      end else if (rd_word == `CAF_ADDR_MSKSEL0 || rd_word == `CAF_ADDR_MSKSEL1) begin
         rd_data = msksel_q[rd_word[2]];
      end else if (rd_word == `CAF_ADDR_FLTACT) begin
         rd_data = fltact_q;
      end else if (rd_word == `CAF_ADDR_STATUS) begin
         rd_data = hits_q;
      end else if (rd_word >= `CAF_ADDR_MASK_BASE && rd_word < `CAF_ADDR_MASK_END) begin
         rd_data = mask_q[rd_word[4:2]];
      end else if (rd_word >= `CAF_ADDR_SID_BASE && rd_word < `CAF_ADDR_EID_BASE) begin
         rd_data = sid_q[rd_word[5:2]];
      end else if (rd_word >= `CAF_ADDR_EID_BASE && rd_word < `CAF_ADDR_EID_END) begin
         rd_data = eid_q[rd_word[5:2]];
      end else if (rd_word == `CAF_ADDR_COUNT) begin
         rd_data = accept_count_q;
      end else begin
         rd_ok = 1'b0;
      end
   end

   caf_axil_slave u_bus (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axil_awaddr(s_axil_awaddr),
      .s_axil_awvalid(s_axil_awvalid),
      .s_axil_awready(s_axil_awready),
      .s_axil_wdata(s_axil_wdata),
      .s_axil_wstrb(s_axil_wstrb),
      .s_axil_wvalid(s_axil_wvalid),
      .s_axil_wready(s_axil_wready),
      .s_axil_bresp(s_axil_bresp),
      .s_axil_bvalid(s_axil_bvalid),
      .s_axil_bready(s_axil_bready),
      .s_axil_araddr(s_axil_araddr),
      .s_axil_arvalid(s_axil_arvalid),
      .s_axil_arready(s_axil_arready),
      .s_axil_rdata(s_axil_rdata),
      .s_axil_rresp(s_axil_rresp),
      .s_axil_rvalid(s_axil_rvalid),
      .s_axil_rready(s_axil_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_ok(wr_ok),
      .rd_addr(rd_addr),
      .rd_data(rd_data),
      .rd_ok(rd_ok)
   );
endmodule // caf_rx_acceptance_filter

// ==== verification/caf_rx_acceptance_filter_monitor.sv ====
`timescale 1ns/1ns
module caf_rx_acceptance_filter_monitor #(
   parameter NUM_FILTERS = 16
) (
   input logic aclk,
   input logic aresetn,
   input logic s_axil_awvalid,
   input logic s_axil_awready,
   input logic s_axil_bvalid,
   input logic s_axil_arvalid,
   input logic s_axil_arready,
   input logic [31:0] s_axil_rdata,
   input logic [1:0] s_axil_rresp,
   input logic s_axil_rvalid,
   input logic msg_valid,
   input logic accept_valid,
   input logic accept_to_fifo,
   input logic [3:0] accept_buffer,
   input logic [3:0] accept_filter
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   property p_cause; accept_valid |-> $past(msg_valid); endproperty
   a_cause: assert property (p_cause) else $error("accept without message");
   property p_fifo; accept_valid && accept_buffer == 4'hF |-> accept_to_fifo; endproperty
   a_fifo: assert property (p_fifo) else $error("pointer 15 not sent to fifo");
   property p_buf; accept_valid && accept_buffer != 4'hF |-> !accept_to_fifo; endproperty
   a_buf: assert property (p_buf) else $error("buffer pointer sent to fifo");
   // Guard on the past reset: a one-edge reset would otherwise look like a change
   property p_hold; $past(aresetn) && !accept_valid |-> $stable({accept_to_fifo, accept_buffer, accept_filter});
   endproperty
   a_hold: assert property (p_hold) else $error("steering changed without accept");
   property p_rans; s_axil_arvalid && s_axil_arready |=> s_axil_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bans; s_axil_awvalid && s_axil_awready |-> ##[1:3] s_axil_bvalid; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   property p_rdhi; s_axil_rvalid |-> s_axil_rdata[31:16] == 16'h0000; endproperty
   a_rdhi: assert property (p_rdhi) else $error("upper read half not zero");
   property p_rerr; s_axil_rvalid && s_axil_rresp != 2'h0 |-> s_axil_rdata == 32'h0; endproperty
   a_rerr: assert property (p_rerr) else $error("refused read carries data");
endmodule // caf_rx_acceptance_filter_monitor
bind caf_rx_acceptance_filter caf_rx_acceptance_filter_monitor #(.NUM_FILTERS(NUM_FILTERS)) u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
   .s_axil_bvalid(s_axil_bvalid), .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
   .s_axil_rdata(s_axil_rdata), .s_axil_rresp(s_axil_rresp), .s_axil_rvalid(s_axil_rvalid),
   .msg_valid(msg_valid), .accept_valid(accept_valid), .accept_to_fifo(accept_to_fifo),
   .accept_buffer(accept_buffer), .accept_filter(accept_filter)
);

// ==== verification/caf_can_node.sv ====
`timescale 1ns/1ns
module caf_can_node (
   input logic aclk,
   output logic msg_valid = 1'h0,
   output logic [10:0] msg_sid = 11'h7FF,
   output logic [17:0] msg_eid = 18'h3FFFF,
   output logic msg_ext = 1'h1
);
   task send(input logic [10:0] standard_identifier_bits, input logic [17:0] extended_identifier_bits, input logic ext);
      @(posedge aclk);
      msg_valid <= 1'h1;
      msg_sid <= standard_identifier_bits;
      msg_eid <= extended_identifier_bits;
      msg_ext <= ext;
      @(posedge aclk);
      // Stale id lines flipped so the block cannot lean on them
      msg_valid <= 1'h0;
      msg_sid <= ~standard_identifier_bits;
      msg_eid <= ~extended_identifier_bits;
      msg_ext <= ~ext;
   endtask
endmodule // caf_can_node

// ==== verification/caf_rx_acceptance_filter_bench.sv ====
`timescale 1ns/1ns
module caf_rx_acceptance_filter_bench;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   wire awready, wready, bvalid, arready, rvalid, mv, mx, acc, afifo;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire [10:0] msid;
   wire [17:0] meid;
   wire [3:0] abuf, aflt;
   int n_fail = 0;
   int checked = 0;
   always #10 aclk = ~aclk;
   caf_rx_acceptance_filter #(.NUM_FILTERS(16)) u_caf_rx_acceptance_filter (
      .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
      .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid),
      .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
      .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
      .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready), .msg_valid(mv),
      .msg_sid(msid), .msg_eid(meid), .msg_ext(mx), .accept_valid(acc), .accept_to_fifo(afifo),
      .accept_buffer(abuf), .accept_filter(aflt)
   );
   caf_can_node u_caf_can_node (
      .aclk(aclk), .msg_valid(mv), .msg_sid(msid), .msg_eid(meid), .msg_ext(mx)
   );
   task report_and_stop;
      if (n_fail == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'h0;
         if (wready)
            wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(32'(bresp), 32'(resp));
   endtask
   task axi_rd(input logic [7:0] a, input logic [15:0] d, input logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, {16'h0000, d});
      chk(32'(rresp), 32'(resp));
   endtask
   task msg(input logic [10:0] s, input logic [17:0] e, input logic x, input logic hit,
            input logic [3:0] f, input logic [3:0] b);
      u_caf_can_node.send(s, e, x);
      #1;
      chk(32'(acc), 32'(hit));
      if (hit)
         chk({afifo, abuf, aflt}, {b == 4'hF, b, f});
   endtask
   task t_reset_regs;
      for (int k = 0; k < 6; k++)
         axi_rd(8'(4 * k), 16'h0000, 2'h0);
      axi_rd(8'h18, 16'hFFFF, 2'h0);
      axi_rd(8'hFC, 16'h0000, 2'h2);
      axi_wr(8'hF0, 16'h1234, 2'h2);
      axi_wr(8'h7C, 16'hFFFF, 2'h0);
      axi_rd(8'h7C, 16'hFFEB, 2'h0);
   endtask
   task t_pointers;
      logic [15:0] v;
      axi_wr(8'h10, 16'hFFFF, 2'h0);
      axi_wr(8'h14, 16'hFFFF, 2'h0);
      for (int k = 0; k < 4; k++) begin
         for (int j = 0; j < 4; j++)
            v[4 * j +: 4] = 4'(15 - 4 * k - j);
         axi_wr(8'(4 * k), v, 2'h0);
         axi_rd(8'(4 * k), v, 2'h0);
      end
      for (int n = 0; n < 16; n++) begin
         axi_wr(8'(8'h40 + 4 * n), 16'(n << 5), 2'h0);
         msg(11'(n), 18'h0, 1'h0, 1'h1, 4'(n), 4'(15 - n));
      end
   endtask
   task t_ident;
      axi_wr(8'h4C, 16'h006A, 2'h0);
      axi_wr(8'h8C, 16'h1234, 2'h0);
      msg(11'h003, 18'h21234, 1'h1, 1'h1, 4'h3, 4'hC);
      msg(11'h003, 18'h21234, 1'h0, 1'h0, 4'h0, 4'h0);
      msg(11'h003, 18'h21235, 1'h1, 1'h0, 4'h0, 4'h0);
      msg(11'h003, 18'h01234, 1'h1, 1'h0, 4'h0, 4'h0);
      msg(11'h013, 18'h21234, 1'h1, 1'h0, 4'h0, 4'h0);
   endtask
   task t_masks;
      // Only the selected mask is live, so a wrong pick lets sid 7 through
      for (int m = 0; m < 3; m++) begin
         axi_wr(8'(8'h20 + 8 * m), 16'hFFE0, 2'h0);
         axi_wr(8'h10, 16'hF3FF | 16'(m << 10), 2'h0);
         msg(11'h005, 18'h3FFFF, 1'h1, 1'h1, 4'h5, 4'hA);
         msg(11'h007, 18'h3FFFF, 1'h1, 1'h0, 4'h0, 4'h0);
         axi_wr(8'(8'h20 + 8 * m), 16'h0000, 2'h0);
      end
      axi_wr(8'h30, 16'hFFE8, 2'h0);
      msg(11'h005, 18'h3FFFF, 1'h1, 1'h0, 4'h0, 4'h0);
      msg(11'h005, 18'h3FFFF, 1'h0, 1'h1, 4'h5, 4'hA);
      axi_wr(8'h30, 16'hFFC8, 2'h0);
      msg(11'h004, 18'h3FFFF, 1'h0, 1'h1, 4'h5, 4'hA);
      msg(11'h004, 18'h0, 1'h0, 1'h1, 4'h4, 4'hB);
      axi_rd(8'h1C, 16'h0030, 2'h0);
      // Extended mask bit 0 now compared
      axi_wr(8'h34, 16'h0001, 2'h0);
      msg(11'h004, 18'h00001, 1'h0, 1'h0, 4'h0, 4'h0);
      msg(11'h004, 18'h3FFFE, 1'h0, 1'h1, 4'h5, 4'hA);
      axi_wr(8'h18, 16'hFFDF, 2'h0);
      msg(11'h004, 18'h3FFFF, 1'h0, 1'h0, 4'h0, 4'h0);
      axi_rd(8'hC0, 16'h0018, 2'h0);
   endtask
   task t_rereset;
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      chk(32'({acc, afifo, abuf, aflt}), 32'h0);
      axi_rd(8'h18, 16'hFFFF, 2'h0);
      axi_rd(8'h00, 16'h0000, 2'h0);
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'h1;
      t_reset_regs();
      t_pointers();
      t_ident();
      t_masks();
      t_rereset();
      report_and_stop();
   end
   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end
endmodule // caf_rx_acceptance_filter_bench
